// ==== shared/pptc_cfg.svh ====
`ifndef PPTC_CFG_SVH
`define PPTC_CFG_SVH

// Register byte addresses
`define PPTC_ADDR_PCM_CONF     8'h55
`define PPTC_ADDR_ROUTING      8'h56
`define PPTC_ADDR_PLL_DIV      8'h61
`define PPTC_ADDR_OVERSAMPLE_CLOCK_SEL     8'h63
`define PPTC_ADDR_FRAC_LO      8'h64
`define PPTC_ADDR_FRAC_HI      8'h65
`define PPTC_ADDR_FRAMES_LO    8'h67
`define PPTC_ADDR_FRAMES_MID   8'h68
`define PPTC_ADDR_FRAMES_HI    8'h69
`define PPTC_ADDR_MEAN_RATE    8'h6a
`define PPTC_ADDR_FW_REV       8'h71
`define PPTC_ADDR_GO           8'h72
`define PPTC_ADDR_TREBLE_LO    8'h77
`define PPTC_ADDR_TREBLE_HI    8'h78
`define PPTC_ADDR_BASS_LO      8'h79
`define PPTC_ADDR_BASS_HI      8'h7a

// Reset values
`define PPTC_RST_PCM_CONF      8'h21
`define PPTC_RST_ROUTING       2'h0
`define PPTC_RST_PLL_DIV       5'h07
`define PPTC_RST_FRAC_LO       8'h46
`define PPTC_RST_FRAC_HI       8'h5b
`define PPTC_RST_FRAMES        24'h000000
`define PPTC_RST_CLEAR_BYTE    8'h00
`define PPTC_RST_CLEAR_BIT     1'b0

// Frame counter step per decoded frame
`define PPTC_FRAME_STEP        24'h000001

// Sample width codes and frame lengths in bit periods
`define PPTC_SAMPLE_WIDTH_SEL_16           2'h0
`define PPTC_SLOTS_SHORT       6'h10
`define PPTC_SLOTS_LONG        6'h20
`define PPTC_FRAME_SHORT       7'h20
`define PPTC_FRAME_LONG        7'h40

// Oversampling ratios (times Fs)
`define PPTC_OS_512            10'h200
`define PPTC_OS_384            10'h180
`define PPTC_OS_256            10'h100
`define PPTC_OS_FIXED          10'h000

// Field positions
`define PPTC_SAMPLE_WIDTH_SEL_MSB          1
`define PPTC_DIV_MSB           4
`define PPTC_ROUTE_MSB         1

// Arbitrary neutral revision code
`define PPTC_FW_REV_DEFAULT    8'h01

`endif

// ==== shared/pptc_pkg.sv ====
package pptc_pkg;

	typedef enum logic [1:0] {
		PPTC_ROUTE_STRAIGHT,
		PPTC_ROUTE_LEFT_BOTH,
		PPTC_ROUTE_RIGHT_BOTH,
		PPTC_ROUTE_SWAP
	} pptc_route_t;

	typedef enum logic [1:0] {
		PPTC_ST_IDLE,
		PPTC_ST_DECODE
	} pptc_run_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pptc_bus_t;

	typedef struct packed {
		logic        frameDone;
		logic        syncReached;
		logic        bootDone;
		logic [7:0]  fwRevision;
		logic [7:0]  meanRate;
		logic        divWrite;
		logic [4:0]  divValue;
		logic        fracLoad;
		logic [15:0] fracValue;
	} pptc_core_t;

	typedef struct packed {
		logic [1:0]  sampleWidthSel;
		logic [5:0]  slotsPerSample;
		logic [6:0]  bitsPerFrame;
		pptc_route_t channelRouting;
		logic [4:0]  pllOutputDivider;
		logic        oclkFixed;
		logic [9:0]  trackRatio;
		logic [15:0] pllFraction;
		logic        decodeRun;
		logic [15:0] trebleCorner;
		logic [15:0] bassCorner;
	} pptc_cfg_t;

	typedef struct packed {
		logic [7:0]  pcm_out_config;
		pptc_route_t routing;
		logic [4:0]  pllDiv;
		logic        oclkFixed;
		logic [7:0]  fracLo;
		logic [7:0]  fracHi;
		logic [23:0] frames;
		logic [7:0]  meanRate;
		logic [7:0]  fwRev;
		logic        go;
		pptc_run_t   runState;
		logic [7:0]  trebleLo;
		logic [7:0]  trebleHi;
		logic [7:0]  bassLo;
		logic [7:0]  bassHi;
		logic [7:0]  rdata;
	} pptc_state_t;

endpackage

// ==== logic/pptc_regs.sv ====
`timescale 1ns/1ns
`include "pptc_cfg.svh"
// Overview of operation
// - Precision code picks width and slot count
// - Frame carries 32 or 64 bit periods
// - Routing: straight, left both, right both, swap
// - Divider X divides VCO by X+1
// - Core rewrites divider; software may too
// - Mode bit: fixed clock or tracking Fs
// - Tracking default is 256 times Fs
// - Fraction is high times 256 plus low
// - Fraction loaded by core at sync
// - 24-bit frame counter counts decoded frames
// - Read-only byte reports average bitrate
// - Read-only byte holds firmware revision
// - Writing go bit starts decoding
// - 16-bit treble corner in hertz
// - 16-bit bass corner in hertz
// - Precision in bits 1:0, reset 0x21
module pptc_regs (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire logic              softReset,
	// Register port
	input  wire pptc_pkg::pptc_bus_t bus,
	output logic [7:0]             rdata,
	// Decoder core
	input  wire pptc_pkg::pptc_core_t core,
	// Configuration out; sample path in and out
	output pptc_pkg::pptc_cfg_t    cfg,
	input  wire logic [15:0]       leftIn,
	input  wire logic [15:0]       rightIn,
	output logic [15:0]            leftOut,
	output logic [15:0]            rightOut
);
	import pptc_pkg::*;

	pptc_state_t stateQ;
	pptc_state_t stateD;

	// =====================================================
	// Helpers
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] ref_a);
		hit = (a == ref_a);
	endfunction

	// =====================================================
	// Next state
	always_comb begin
		stateD = stateQ;
		stateD.rdata = 8'h00;
		// Frame counter advances on each decoded frame
		if (core.frameDone) begin
			stateD.frames = stateQ.frames + `PPTC_FRAME_STEP;
		end
		stateD.meanRate = core.meanRate;
		if (core.bootDone) begin
			stateD.fwRev = core.fwRevision;
		end
		if (bus.wr) begin
			// Read-only addresses fall through untouched
			if (hit(bus.addr, `PPTC_ADDR_PCM_CONF)) begin
				stateD.pcm_out_config = bus.wdata;
			end else if (hit(bus.addr, `PPTC_ADDR_ROUTING)) begin
				stateD.routing = pptc_route_t'(
					bus.wdata[`PPTC_ROUTE_MSB:0]);
			end else if (hit(bus.addr, `PPTC_ADDR_PLL_DIV)) begin
				stateD.pllDiv = bus.wdata[`PPTC_DIV_MSB:0];
			end else if (hit(bus.addr, `PPTC_ADDR_OVERSAMPLE_CLOCK_SEL)) begin
				stateD.oclkFixed = bus.wdata[0];
			end else if (hit(bus.addr, `PPTC_ADDR_FRAC_LO)) begin
				stateD.fracLo = bus.wdata;
			end else if (hit(bus.addr, `PPTC_ADDR_FRAC_HI)) begin
				stateD.fracHi = bus.wdata;
			end else if (hit(bus.addr, `PPTC_ADDR_GO)) begin
				stateD.go = bus.wdata[0];
			end else if (hit(bus.addr, `PPTC_ADDR_TREBLE_LO)) begin
				stateD.trebleLo = bus.wdata;
			end else if (hit(bus.addr, `PPTC_ADDR_TREBLE_HI)) begin
				stateD.trebleHi = bus.wdata;
			end else if (hit(bus.addr, `PPTC_ADDR_BASS_LO)) begin
				stateD.bassLo = bus.wdata;
			end else if (hit(bus.addr, `PPTC_ADDR_BASS_HI)) begin
				stateD.bassHi = bus.wdata;
			end
		end
		// Core overrides software in the same cycle: it owns the clocking
		if (core.divWrite) begin
			stateD.pllDiv = core.divValue;
		end
		if (core.syncReached && core.fracLoad) begin
			stateD.fracLo = core.fracValue[7:0];
			stateD.fracHi = core.fracValue[15:8];
		end
		// Decode sequencing
		case (stateQ.runState)
			PPTC_ST_IDLE: begin
				if (stateQ.go) begin
					stateD.runState = PPTC_ST_DECODE;
				end
			end
			PPTC_ST_DECODE: begin
				if (!stateQ.go) begin
					stateD.runState = PPTC_ST_IDLE;
				end
			end
			default: begin
				stateD.runState = PPTC_ST_IDLE;
			end
		endcase
		if (bus.rd) begin
			if (hit(bus.addr, `PPTC_ADDR_PCM_CONF)) begin
				stateD.rdata = stateQ.pcm_out_config;
			end else if (hit(bus.addr, `PPTC_ADDR_ROUTING)) begin
				stateD.rdata = {6'h00, stateQ.routing};
			end else if (hit(bus.addr, `PPTC_ADDR_PLL_DIV)) begin
				stateD.rdata = {3'h0, stateQ.pllDiv};
			end else if (hit(bus.addr, `PPTC_ADDR_OVERSAMPLE_CLOCK_SEL)) begin
				stateD.rdata = {7'h00, stateQ.oclkFixed};
			end else if (hit(bus.addr, `PPTC_ADDR_FRAC_LO)) begin
				stateD.rdata = stateQ.fracLo;
			end else if (hit(bus.addr, `PPTC_ADDR_FRAC_HI)) begin
				stateD.rdata = stateQ.fracHi;
			end else if (hit(bus.addr, `PPTC_ADDR_FRAMES_LO)) begin
				stateD.rdata = stateQ.frames[7:0];
			end else if (hit(bus.addr, `PPTC_ADDR_FRAMES_MID)) begin
				stateD.rdata = stateQ.frames[15:8];
			end else if (hit(bus.addr, `PPTC_ADDR_FRAMES_HI)) begin
				stateD.rdata = stateQ.frames[23:16];
			end else if (hit(bus.addr, `PPTC_ADDR_MEAN_RATE)) begin
				stateD.rdata = stateQ.meanRate;
			end else if (hit(bus.addr, `PPTC_ADDR_FW_REV)) begin
				stateD.rdata = stateQ.fwRev;
			end else if (hit(bus.addr, `PPTC_ADDR_GO)) begin
				stateD.rdata = {7'h00, stateQ.go};
			end else if (hit(bus.addr, `PPTC_ADDR_TREBLE_LO)) begin
				stateD.rdata = stateQ.trebleLo;
			end else if (hit(bus.addr, `PPTC_ADDR_TREBLE_HI)) begin
				stateD.rdata = stateQ.trebleHi;
			end else if (hit(bus.addr, `PPTC_ADDR_BASS_LO)) begin
				stateD.rdata = stateQ.bassLo;
			end else if (hit(bus.addr, `PPTC_ADDR_BASS_HI)) begin
				stateD.rdata = stateQ.bassHi;
			end
		end
		// Software reset restores documented defaults, frame count too
		if (softReset) begin
			stateD.pcm_out_config = `PPTC_RST_PCM_CONF;
			stateD.routing = pptc_route_t'(`PPTC_RST_ROUTING);
			stateD.pllDiv = `PPTC_RST_PLL_DIV;
			stateD.oclkFixed = `PPTC_RST_CLEAR_BIT;
			stateD.fracLo = `PPTC_RST_FRAC_LO;
			stateD.fracHi = `PPTC_RST_FRAC_HI;
			stateD.frames = `PPTC_RST_FRAMES;
			stateD.go = `PPTC_RST_CLEAR_BIT;
			stateD.runState = PPTC_ST_IDLE;
			stateD.trebleLo = `PPTC_RST_CLEAR_BYTE;
			stateD.trebleHi = `PPTC_RST_CLEAR_BYTE;
			stateD.bassLo = `PPTC_RST_CLEAR_BYTE;
			stateD.bassHi = `PPTC_RST_CLEAR_BYTE;
		end
	end

	// =====================================================
	// State register
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			stateQ <= '0;
			stateQ.pcm_out_config <= `PPTC_RST_PCM_CONF;
			stateQ.pllDiv <= `PPTC_RST_PLL_DIV;
			// Hardware leaves the fraction undefined; use soft values
			stateQ.fracLo <= `PPTC_RST_FRAC_LO;
			stateQ.fracHi <= `PPTC_RST_FRAC_HI;
			stateQ.fwRev <= `PPTC_FW_REV_DEFAULT;
			stateQ.runState <= PPTC_ST_IDLE;
		end else begin
			stateQ <= stateD;
		end
	end

	// =====================================================
	// Outputs
	assign rdata = stateQ.rdata;

	always_comb begin
		cfg = '0;
		cfg.sampleWidthSel = stateQ.pcm_out_config[`PPTC_SAMPLE_WIDTH_SEL_MSB:0];
		if (cfg.sampleWidthSel == `PPTC_SAMPLE_WIDTH_SEL_16) begin
			cfg.slotsPerSample = `PPTC_SLOTS_SHORT;
			cfg.bitsPerFrame = `PPTC_FRAME_SHORT;
		end else begin
			cfg.slotsPerSample = `PPTC_SLOTS_LONG;
			cfg.bitsPerFrame = `PPTC_FRAME_LONG;
		end
		cfg.channelRouting = stateQ.routing;
		cfg.pllOutputDivider = stateQ.pllDiv;
		cfg.oclkFixed = stateQ.oclkFixed;
		// Tracking mode ratio; 256 Fs is the default 12.288 MHz point
		cfg.trackRatio = stateQ.oclkFixed ? `PPTC_OS_FIXED
			: `PPTC_OS_256;
		cfg.pllFraction = {stateQ.fracHi, stateQ.fracLo};
		cfg.decodeRun = (stateQ.runState == PPTC_ST_DECODE);
		cfg.trebleCorner = {stateQ.trebleHi, stateQ.trebleLo};
		cfg.bassCorner = {stateQ.bassHi, stateQ.bassLo};
	end

	// Channel routing is combinational on the sample path
	always_comb begin
		case (stateQ.routing)
			PPTC_ROUTE_LEFT_BOTH: begin
				leftOut = leftIn;
				rightOut = leftIn;
			end
			PPTC_ROUTE_RIGHT_BOTH: begin
				leftOut = rightIn;
				rightOut = rightIn;
			end
			PPTC_ROUTE_SWAP: begin
				leftOut = rightIn;
				rightOut = leftIn;
			end
			default: begin
				leftOut = leftIn;
				rightOut = rightIn;
			end
		endcase
	end

endmodule

// ==== sim/pptc_regs_properties.sv ====
`timescale 1ns/1ns
module pptc_regs_props (
	// Clock and reset
	input wire logic                 ref_clk,
	input wire logic                 rstn,
	input wire logic                 softReset,
	// Watched ports
	input wire pptc_pkg::pptc_bus_t  bus,
	input wire logic [7:0]           rdata,
	input wire pptc_pkg::pptc_core_t core,
	input wire pptc_pkg::pptc_cfg_t  cfg,
	input wire logic [15:0]          leftIn,
	input wire logic [15:0]          rightIn,
	input wire logic [15:0]          leftOut,
	input wire logic [15:0]          rightOut
);
	import pptc_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// =============
	// Properties
	logic wrOk;
	assign wrOk = bus.wr && !softReset;
	a_rdata_idle: assert property (
		!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data not idle");
	a_short_frame: assert property (
		cfg.sampleWidthSel == 2'h0 |->
		cfg.slotsPerSample == 6'h10 && cfg.bitsPerFrame == 7'h20)
		else $error("short frame wrong");
	a_long_frame: assert property (
		cfg.sampleWidthSel != 2'h0 |->
		cfg.slotsPerSample == 6'h20 && cfg.bitsPerFrame == 7'h40)
		else $error("long frame wrong");
	a_route_swap: assert property (
		cfg.channelRouting == PPTC_ROUTE_SWAP |->
		leftOut == rightIn && rightOut == leftIn)
		else $error("swap wrong");
	a_route_dup: assert property (
		cfg.channelRouting == PPTC_ROUTE_LEFT_BOTH |->
		leftOut == leftIn && rightOut == leftIn)
		else $error("dup wrong");
	a_route_right: assert property (
		cfg.channelRouting == PPTC_ROUTE_RIGHT_BOTH |->
		leftOut == rightIn && rightOut == rightIn)
		else $error("right dup wrong");
	a_track_default: assert property (
		!cfg.oclkFixed |-> cfg.trackRatio == 10'h100)
		else $error("tracking ratio wrong");
	// A soft reset right after the write legally cancels the start
	a_go_start: assert property (
		(wrOk && bus.addr == 8'h72 && bus.wdata[0]) ##1 !softReset
		|-> ##1 cfg.decodeRun) else $error("decode did not start");
	a_core_divider: assert property (
		core.divWrite && !softReset |=>
		cfg.pllOutputDivider == $past(core.divValue))
		else $error("core divider lost");
	a_sw_divider: assert property (
		wrOk && bus.addr == 8'h61 && !core.divWrite |=>
		{3'h0, cfg.pllOutputDivider} == ($past(bus.wdata) & 8'h1f))
		else $error("divider write lost");
	a_frac_load: assert property (
		core.syncReached && core.fracLoad && !softReset |=>
		cfg.pllFraction == $past(core.fracValue))
		else $error("fraction load lost");
	a_soft_defaults: assert property (
		softReset |=> cfg.pllOutputDivider == 5'h07
		&& cfg.pllFraction == 16'h5b46) else $error("soft reset values wrong");
endmodule
bind pptc_regs pptc_regs_props pptc_regs_props_inst (.ref_clk(ref_clk),
	.rstn(rstn), .softReset(softReset), .bus(bus), .rdata(rdata),
	.core(core), .cfg(cfg), .leftIn(leftIn), .rightIn(rightIn),
	.leftOut(leftOut), .rightOut(rightOut));

// ==== sim/pptc_regs_tb.sv ====
`timescale 1ns/1ns
`include "pptc_cfg.svh"
module pptc_regs_tb;
	import pptc_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        softReset = 1'b0;
	pptc_bus_t   bus = '0;
	pptc_core_t  core = '0;
	logic [15:0] leftIn = 16'h1234;
	logic [15:0] rightIn = 16'habcd;
	logic [7:0]  rdata;
	pptc_cfg_t   cfg;
	logic [15:0] leftOut;
	logic [15:0] rightOut;
	int          errTotal = 0;
	int          nCompared = 0;
	logic [7:0]  rstAddr [17] = '{8'h55, 8'h56, 8'h61, 8'h63, 8'h64, 8'h65,
		8'h67, 8'h68, 8'h69, 8'h6a, 8'h71, 8'h72, 8'h77, 8'h78, 8'h79, 8'h7a,
		8'h40};
	logic [7:0]  rstVal [17] = '{8'h21, 8'h00, 8'h07, 8'h00, 8'h46, 8'h5b,
		8'h00, 8'h00, 8'h00, 8'h00, `PPTC_FW_REV_DEFAULT, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00};
	logic [31:0] routeExp [4] = '{32'h1234abcd, 32'h12341234, 32'habcdabcd,
		32'habcd1234};
	always #10 ref_clk = ~ref_clk;
	pptc_regs pptc_regs_inst (.ref_clk(ref_clk), .rstn(rstn),
		.softReset(softReset), .bus(bus), .rdata(rdata), .core(core),
		.cfg(cfg), .leftIn(leftIn), .rightIn(rightIn), .leftOut(leftOut),
		.rightOut(rightOut));
	// =============
	// Access tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			errTotal++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic give_verdict;
		$display("Compared %0d, mismatches %0d", nCompared, errTotal);
		if (errTotal == 0 && nCompared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Tests need about 390 cycles; the limit of 5000 cycles allows over twelve times that
	initial begin
		#100000;
		errTotal++;
		give_verdict();
	end
	// =============
	// Tests
	initial begin
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 17; i++)
			rd(rstAddr[i], rstVal[i]);
		for (int i = 0; i < 4; i++) begin
			wr(8'h55, 8'h20 | 8'(i));
			wr(8'h56, 8'(i));
			#1 chk(cfg.sampleWidthSel, 32'(i));
			chk(cfg.slotsPerSample, i ? 32'h20 : 32'h10);
			chk(cfg.bitsPerFrame, i ? 32'h40 : 32'h20);
			chk({leftOut, rightOut}, routeExp[i]);
		end
		wr(8'h61, 8'h0c);
		rd(8'h61, 8'h0c);
		chk(cfg.pllOutputDivider, 32'h0c);
		// Core and software hit the divider in the same cycle
		@(posedge ref_clk);
		core.divWrite <= 1'b1;
		core.divValue <= 5'h03;
		bus <= '{addr: 8'h61, wdata: 8'h1f, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		core.divWrite <= 1'b0;
		bus.wr <= 1'b0;
		rd(8'h61, 8'h03);
		wr(8'h63, 8'h01);
		#1 chk({cfg.oclkFixed, cfg.trackRatio}, 32'h400);
		wr(8'h63, 8'h00);
		#1 chk({cfg.oclkFixed, cfg.trackRatio}, 32'h100);
		wr(8'h64, 8'h11);
		wr(8'h65, 8'h22);
		#1 chk(cfg.pllFraction, 32'h2211);
		@(posedge ref_clk);
		core.syncReached <= 1'b1;
		core.fracLoad <= 1'b1;
		core.fracValue <= 16'hbeef;
		core.meanRate <= 8'h80;
		@(posedge ref_clk);
		core.fracLoad <= 1'b0;
		rd(8'h65, 8'hbe);
		rd(8'h64, 8'hef);
		// 257 frames carry the low byte into the middle one
		@(posedge ref_clk);
		core.frameDone <= 1'b1;
		repeat (257) @(posedge ref_clk);
		core.frameDone <= 1'b0;
		wr(8'h67, 8'hff);
		wr(8'h6a, 8'h00);
		rd(8'h67, 8'h01);
		rd(8'h68, 8'h01);
		rd(8'h69, 8'h00);
		rd(8'h6a, 8'h80);
		@(posedge ref_clk);
		core.fwRevision <= 8'h3c;
		core.bootDone <= 1'b1;
		wr(8'h71, 8'h00);
		rd(8'h71, 8'h3c);
		// Corners stay legal: treble below Fs/2, bass in 0..treble
		wr(8'h77, 8'hb8);
		wr(8'h78, 8'h0b);
		wr(8'h79, 8'hc8);
		wr(8'h7a, 8'h00);
		#1 chk(cfg.trebleCorner, 32'h0bb8);
		chk(cfg.bassCorner, 32'h00c8);
		wr(8'h72, 8'h01);
		@(posedge ref_clk);
		#1 chk(cfg.decodeRun, 32'h1);
		@(posedge ref_clk);
		softReset <= 1'b1;
		@(posedge ref_clk);
		softReset <= 1'b0;
		rd(8'h67, 8'h00);
		rd(8'h64, 8'h46);
		rd(8'h56, 8'h00);
		chk(cfg.decodeRun, 32'h0);
		// A second hardware reset in mid-run clears the count again
		@(posedge ref_clk);
		core.frameDone <= 1'b1;
		@(posedge ref_clk);
		core.frameDone <= 1'b0;
		wr(8'h55, 8'h22);
		rd(8'h67, 8'h01);
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(8'h67, 8'h00);
		rd(8'h55, 8'h21);
		give_verdict();
	end
endmodule
